//--- bir_top.sv
// interrupt request pin, type/source/status registers and event queue of the transceiver
`timescale 1ns/1ps
//
// Summary of operation
// - main node raises running type 0xff after pll lock; main node only.
// - discovery response raises type 0x18; main node only.
// - every line fault raises a request, during or after discovery.
// - in the reset state the request pin floats, nothing else is shown.
// - status and type registers read 0x00 after entering the reset state.
// - polarity bit 0 gives active high request, 1 gives active low.
// - setting main enable drives the pin, inactive unless a request is already pending; host ignores pin before that.
// - bus errors report types 0x0, 0x1, 0x2, 0x3 and 0x4.
// - missed super-frame reports 0x5; ten uncleared ones mean line lost.
// - super-frame check error 0x6 is raised by a subordinate node only.
// - remote access error 0x19 is raised by a main node only.
// - interrupt frame check error 0x1a is raised by a main node only.
// - general pin n interrupt reports type 0x10 plus n, for pins 0 to 7.
module bir_top
  import bir_pkg::*;
#(
  parameter int GPIO_N = 8
) (
  input  wire logic              mclk_i,
  input  wire logic              arst_n_i,
  input  wire logic [AW-1:0]     addr_i,
  input  wire logic [DW-1:0]     wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DW-1:0]     rdata_o,
  input  wire logic              rst_state_i,
  input  wire logic              line_fault_i,
  input  wire logic              main_running_event_i,
  input  wire logic              discovery_complete_event_i,
  input  wire logic              header_count_error_i,
  input  wire logic              data_decode_error_i,
  input  wire logic              frame_check_error_i,
  input  wire logic              data_parity_error_i,
  input  wire logic              bit_error_count_overflow_i,
  input  wire logic              missed_superframe_error_i,
  input  wire logic              superframe_check_error_i,
  input  wire logic              remote_access_error_i,
  input  wire logic              interrupt_frame_check_error_i,
  input  wire logic [GPIO_N-1:0] general_pin_event_i,
  output logic                   irq_o,
  output logic                   irq_oe_o,
  output logic                   int_o
);

  localparam int NEV = EV_FIXED + GPIO_N;

  // type codes 0x10..0x17 leave room for eight general pins only
  if (GPIO_N < 1 || GPIO_N > 8) begin : g_bad_gpio
    $error("GPIO_N must lie between 1 and 8");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic [NEV-1:0] que_q,    que_d;
  logic [NEV-1:0] status_q, status_d;
  logic [NEV-1:0] mask_q,   mask_d;
  logic [7:0]     type_q,   type_d;
  logic [IW-1:0]  src_q,    src_d;
  logic           active_q, active_d;
  logic           inv_q,    inv_d;
  logic           en_q,     en_d;
  logic [DW-1:0]  rdata_d;
  logic           irq_d;
  logic           oe_d;
  logic           int_d;
  logic [NEV-1:0] ev;
  logic           rd_type;
  logic           take;
  logic           main_q;

  assign main_q = en_q;

  ////////////////////////////////////////////////////////////////////////////////
  // event gathering, role-restricted codes filtered here

  assign ev = {general_pin_event_i,
               interrupt_frame_check_error_i & main_q,
               remote_access_error_i & main_q,
               superframe_check_error_i & ~main_q,
               missed_superframe_error_i,
               bit_error_count_overflow_i,
               data_parity_error_i,
               frame_check_error_i,
               data_decode_error_i,
               header_count_error_i,
               discovery_complete_event_i & main_q,
               main_running_event_i & main_q,
               line_fault_i};

  ////////////////////////////////////////////////////////////////////////////////
  // arbiter

  bir_arb_if #(.N(NEV)) arb_if ();

  assign arb_if.req = que_q & mask_q;

  bir_arb #(
    .N (NEV)
  ) u_arb (
    .a (arb_if)
  );

  // a type read in the same cycle would drop a freshly taken event
  assign rd_type = rd_i && (addr_i == OFF_TYPE);
  assign take    = !active_q && arb_if.hit && !rd_type;

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    que_d    = que_q;
    status_d = status_q;
    mask_d   = mask_q;
    type_d   = type_q;
    src_d    = src_q;
    active_d = active_q;
    inv_d    = inv_q;
    en_d     = en_q;
    rdata_d  = '0;

    if (take) begin
      active_d           = 1'b1;
      type_d             = arb_if.code;
      src_d              = arb_if.idx;
      que_d[arb_if.idx]  = 1'b0;
    end

    if (rd_i) begin
      case (addr_i)
        OFF_TYPE: begin
          rdata_d  = DW'(type_q);
          active_d = 1'b0;
        end
        OFF_SOURCE: begin
          rdata_d                = DW'(src_q);
          rdata_d[SRC_VALID_BIT] = active_q;
        end
        OFF_STATUS: begin
          rdata_d  = DW'(status_q);
          status_d = '0;
        end
        OFF_MASK:   rdata_d = DW'(mask_q);
        OFF_PIN_CONFIGURATION_REGISTER: rdata_d[PIN_INV_BIT] = inv_q;
        OFF_CTRL:   rdata_d[CTL_EN_BIT] = en_q;
        default:    rdata_d = '0;
      endcase
    end

    if (wr_i) begin
      case (addr_i)
        OFF_MASK:   mask_d = wdata_i[NEV-1:0];
        OFF_PIN_CONFIGURATION_REGISTER: inv_d  = wdata_i[PIN_INV_BIT];
        OFF_CTRL:   en_d   = wdata_i[CTL_EN_BIT];
        default:    mask_d = mask_d;
      endcase
    end

    // new events beat a clear in the same cycle
    que_d    = que_d | ev;
    status_d = status_d | ev;

    if (rst_state_i) begin
      que_d    = '0;
      status_d = RST_STATUS[NEV-1:0];
      mask_d   = RST_MASK[NEV-1:0];
      type_d   = RST_TYPE;
      src_d    = '0;
      active_d = 1'b0;
      inv_d    = RST_INV;
      en_d     = RST_EN;
    end

    irq_d = active_d ^ inv_d;
    oe_d  = en_d & ~rst_state_i;
    int_d = |(status_d & mask_d);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      que_q    <= '0;
      status_q <= RST_STATUS[NEV-1:0];
      mask_q   <= RST_MASK[NEV-1:0];
      type_q   <= RST_TYPE;
      src_q    <= '0;
      active_q <= 1'b0;
      inv_q    <= RST_INV;
      en_q     <= RST_EN;
      rdata_o  <= '0;
      irq_o    <= RST_INV;
      irq_oe_o <= 1'b0;
      int_o    <= 1'b0;
    end else begin
      que_q    <= que_d;
      status_q <= status_d;
      mask_q   <= mask_d;
      type_q   <= type_d;
      src_q    <= src_d;
      active_q <= active_d;
      inv_q    <= inv_d;
      en_q     <= en_d;
      rdata_o  <= rdata_d;
      irq_o    <= irq_d;
      irq_oe_o <= oe_d;
      int_o    <= int_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  chk_run_queued: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    main_running_event_i && main_q && !rst_state_i |=> que_q[EV_RUN])
    else $error("running event from main node not queued");

  chk_run_not_sub: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    main_running_event_i && !main_q && !que_q[EV_RUN] |=> !que_q[EV_RUN])
    else $error("running event queued on subordinate node");

  chk_read_clears: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    rd_type && active_q |=> !active_q && irq_o == inv_q)
    else $error("type read did not release the request");

  chk_dsc_code: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    take && !rst_state_i && arb_if.idx == EV_DSC |=> active_q && type_q == CODE_DSC)
    else $error("discovery event not reported as 0x18");

  chk_line_fault: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    line_fault_i && !rst_state_i && mask_q[EV_LINE] && !active_q && !rd_i && !wr_i
    && !arb_if.hit ##1 !rd_type && !rst_state_i
    |-> que_q[EV_LINE] ##1 active_q && type_q == CODE_LINE)
    else $error("line fault did not raise a request");

  chk_reset_hiz: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    rst_state_i |=> !irq_oe_o && !active_q)
    else $error("request pin driven in reset state");

  chk_reset_clear: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    rst_state_i ##1 rd_i && (addr_i == OFF_TYPE || addr_i == OFF_STATUS) && !take
    |=> rdata_o == '0)
    else $error("type or status not zero after reset state");

  chk_polarity: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    irq_o == (active_q ^ inv_q))
    else $error("request level does not follow polarity");

  chk_enable_idle: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    $rose(en_q) && !active_q && !$past(rst_state_i) |-> irq_oe_o && irq_o == inv_q)
    else $error("enable did not drive inactive level");

  chk_type_code: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    take && !rst_state_i |=> active_q && src_q == $past(arb_if.idx)
    && type_q == $past(arb_if.code))
    else $error("type register does not match taken event");

  chk_srf_code: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    take && !rst_state_i && arb_if.idx == EV_SRF |=> type_q == CODE_SRF)
    else $error("missed super-frame not reported as 0x5");

  chk_sfcrc_sub: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    superframe_check_error_i && main_q && !que_q[EV_SFCRC] |=> !que_q[EV_SFCRC])
    else $error("super-frame check error queued on main node");

  chk_i2c_main: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    remote_access_error_i && !main_q && !que_q[EV_I2C] |=> !que_q[EV_I2C])
    else $error("remote access error queued on subordinate node");

  chk_icrc_main: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    interrupt_frame_check_error_i && !main_q && !que_q[EV_ICRC] |=> !que_q[EV_ICRC])
    else $error("interrupt frame check error queued on subordinate node");

  chk_gpio_code: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    take && !rst_state_i && arb_if.idx >= EV_GPIO0
    |=> type_q == CODE_GPIO_BASE + 8'($past(arb_if.idx) - EV_GPIO0))
    else $error("general pin code out of place");

  chk_irq_holds: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
    active_q && !rd_type && !rst_state_i |=> active_q && irq_o == !inv_q)
    else $error("request dropped without a type read");

  cov_running: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    take && arb_if.idx == EV_RUN ##[1:20] rd_type);

  cov_back_to_back: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    rd_type && active_q && |(que_q & mask_q) ##2 active_q);

  cov_inverted: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    inv_q && en_q && active_q);

  cov_reset_state: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    active_q ##1 rst_state_i);

endmodule

//--- bir_pkg.sv
// shared constants, register map and type-code table of the bus interrupt reporter
package bir_pkg;

  localparam int DW = 32;
  localparam int AW = 8;
  localparam int IW = 5;

  // register byte offsets
  localparam logic [AW-1:0] OFF_TYPE   = 8'h00;
  localparam logic [AW-1:0] OFF_SOURCE = 8'h04;
  localparam logic [AW-1:0] OFF_STATUS = 8'h08;
  localparam logic [AW-1:0] OFF_MASK   = 8'h0c;
  localparam logic [AW-1:0] OFF_PIN_CONFIGURATION_REGISTER = 8'h10;
  localparam logic [AW-1:0] OFF_CTRL   = 8'h14;

  // field positions
  localparam int PIN_INV_BIT   = 0;
  localparam int CTL_EN_BIT    = 0;
  localparam int SRC_VALID_BIT = 7;

  // reset values
  localparam logic [7:0]    RST_TYPE   = 8'h00;
  localparam logic [DW-1:0] RST_STATUS = 32'h0000_0000;
  localparam logic [DW-1:0] RST_MASK   = 32'hffff_ffff;
  localparam logic          RST_INV    = 1'b0;
  localparam logic          RST_EN     = 1'b0;

  // interrupt type codes
  localparam logic [7:0] CODE_RUN       = 8'hff;
  localparam logic [7:0] CODE_DSC       = 8'h18;
  localparam logic [7:0] CODE_LINE      = 8'h0a;
  localparam logic [7:0] CODE_HDR       = 8'h00;
  localparam logic [7:0] CODE_DEC       = 8'h01;
  localparam logic [7:0] CODE_CRC       = 8'h02;
  localparam logic [7:0] CODE_PAR       = 8'h03;
  localparam logic [7:0] CODE_BEC       = 8'h04;
  localparam logic [7:0] CODE_SRF       = 8'h05;
  localparam logic [7:0] CODE_SFCRC     = 8'h06;
  localparam logic [7:0] CODE_I2C       = 8'h19;
  localparam logic [7:0] CODE_ICRC      = 8'h1a;
  localparam logic [7:0] CODE_GPIO_BASE = 8'h10;

  // event indices, lowest index wins arbitration
  localparam logic [IW-1:0] EV_LINE  = 5'd0;
  localparam logic [IW-1:0] EV_RUN   = 5'd1;
  localparam logic [IW-1:0] EV_DSC   = 5'd2;
  localparam logic [IW-1:0] EV_HDR   = 5'd3;
  localparam logic [IW-1:0] EV_DEC   = 5'd4;
  localparam logic [IW-1:0] EV_CRC   = 5'd5;
  localparam logic [IW-1:0] EV_PAR   = 5'd6;
  localparam logic [IW-1:0] EV_BEC   = 5'd7;
  localparam logic [IW-1:0] EV_SRF   = 5'd8;
  localparam logic [IW-1:0] EV_SFCRC = 5'd9;
  localparam logic [IW-1:0] EV_I2C   = 5'd10;
  localparam logic [IW-1:0] EV_ICRC  = 5'd11;
  localparam logic [IW-1:0] EV_GPIO0 = 5'd12;
  localparam int            EV_FIXED = 12;

  function automatic logic [7:0] bir_code_of(input logic [IW-1:0] idx);
    logic [IW-1:0] off;
    off = idx - EV_GPIO0;
    case (idx)
      EV_LINE:  bir_code_of = CODE_LINE;
      EV_RUN:   bir_code_of = CODE_RUN;
      EV_DSC:   bir_code_of = CODE_DSC;
      EV_HDR:   bir_code_of = CODE_HDR;
      EV_DEC:   bir_code_of = CODE_DEC;
      EV_CRC:   bir_code_of = CODE_CRC;
      EV_PAR:   bir_code_of = CODE_PAR;
      EV_BEC:   bir_code_of = CODE_BEC;
      EV_SRF:   bir_code_of = CODE_SRF;
      EV_SFCRC: bir_code_of = CODE_SFCRC;
      EV_I2C:   bir_code_of = CODE_I2C;
      EV_ICRC:  bir_code_of = CODE_ICRC;
      default:  bir_code_of = CODE_GPIO_BASE + {3'b000, off};
    endcase
  endfunction

endpackage

//--- bir_arb_if.sv
// request vector and winner between the reporter and its arbiter
`timescale 1ns/1ps
interface bir_arb_if #(
  parameter int N = 20
);
  import bir_pkg::*;
  logic [N-1:0]  req;
  logic          hit;
  logic [IW-1:0] idx;
  logic [7:0]    code;

  modport top (output req, input hit, input idx, input code);
  modport arb (input req, output hit, output idx, output code);
endinterface

//--- bir_arb.sv
// fixed-priority pick of the next pending event and its type code
`timescale 1ns/1ps
module bir_arb
  import bir_pkg::*;
#(
  parameter int N = 20
) (
  bir_arb_if.arb a
);

  // scan from the top so the lowest pending index is left standing
  always_comb begin
    a.hit = 1'b0;
    a.idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (a.req[i]) begin
        a.hit = 1'b1;
        a.idx = IW'(i);
      end
    end
    a.code = bir_code_of(a.idx);
  end

endmodule

//--- bir_host.sv
// host side of the request pin: board pull resistor and active-level decode
`timescale 1ns/1ps
module bir_host (
  input  wire logic irq_i,
  input  wire logic irq_oe_i,
  input  wire logic pull_low_i,
  input  wire logic en_i,
  output logic      pin_o,
  output logic      active_o
);
  // pull resistor chosen to match the polarity, so a floating pin looks active
  assign pin_o    = irq_oe_i ? irq_i : !pull_low_i;
  // pin is ignored until the host has set main enable
  assign active_o = en_i & (pin_o ^ pull_low_i);
endmodule

//--- tb.sv
// self-checking bench for the bus interrupt reporter
`timescale 1ns/1ps
module tb;
  import bir_pkg::*;
  logic          mclk_i, arst_n_i, wr, rd, rst_st, inv, host_en;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, v;
  logic [19:0]   ev;
  logic          irq, oe, intr, pin, act;
  int            num_errors, compares;
  logic [7:0]    codes [20] = '{8'h0a, 8'hff, 8'h18, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                                8'h06, 8'h19, 8'h1a, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
                                8'h15, 8'h16, 8'h17};
  ////////////////////////////////////////////////////////////////////////////////
  bir_top dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rst_state_i(rst_st), .line_fault_i(ev[0]),
    .main_running_event_i(ev[1]), .discovery_complete_event_i(ev[2]),
    .header_count_error_i(ev[3]), .data_decode_error_i(ev[4]), .frame_check_error_i(ev[5]),
    .data_parity_error_i(ev[6]), .bit_error_count_overflow_i(ev[7]),
    .missed_superframe_error_i(ev[8]), .superframe_check_error_i(ev[9]),
    .remote_access_error_i(ev[10]), .interrupt_frame_check_error_i(ev[11]),
    .general_pin_event_i(ev[19:12]), .irq_o(irq), .irq_oe_o(oe), .int_o(intr));
  bir_host host (.irq_i(irq), .irq_oe_i(oe), .pull_low_i(inv), .en_i(host_en),
    .pin_o(pin), .active_o(act));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [DW-1:0] s, input logic [DW-1:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge mclk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_i);
    wr    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge mclk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_i);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic pulse(input logic [19:0] m);
    @(posedge mclk_i);
    ev <= m;
    @(posedge mclk_i);
    ev <= '0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // bounded wait for the host to see the wanted request level
  task automatic wait_act(input logic l);
    int i;
    i = 0;
    while (act !== l && i < 10) begin
      @(posedge mclk_i);
      #1;
      i++;
    end
    if (act !== l) begin
      num_errors++;
      $display("[FAIL] request wait expected %b seen %b", l, act);
      summarize();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [AW-1:0] offs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
    // mask register is only as wide as the event vector
    logic [DW-1:0] rstv [7] = '{0, 0, 0, 32'h000f_ffff, 0, 0, 0};
    arst_n_i = 1'b0; wr = 1'b0; rd = 1'b0; rst_st = 1'b0; inv = 1'b0; host_en = 1'b0;
    addr = '0; wdata = '0; ev = '0; num_errors = 0; compares = 0;
    repeat (12) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    idle(1);
    for (int i = 0; i < 7; i++) begin
      rd_reg(offs[i], v);
      chk("reset value", v, rstv[i]);
    end
    chk("oe in reset", {31'b0, oe}, 0);
    chk("pin pulled", {31'b0, pin}, 1);
    $display("test reset values done");
    wr_reg(OFF_CTRL, 32'h1);
    host_en = 1'b1;
    idle(2);
    chk("oe enabled", {31'b0, oe}, 1);
    chk("irq inactive", {31'b0, irq}, 0);
    $display("test enable done");
    // every event kind except the subordinate-only one
    for (int i = 0; i < 20; i++) begin
      if (i != 9) begin
        pulse(20'(1) << i);
        wait_act(1'b1);
        idle(4);
        chk("request holds", {31'b0, act}, 1);
        chk("int level", {31'b0, intr}, 1);
        rd_reg(OFF_TYPE, v);
        chk("type code", v, {24'b0, codes[i]});
        chk("released", {31'b0, act}, 0);
        rd_reg(OFF_STATUS, v);
        chk("status bit", v, 32'(1) << i);
        rd_reg(OFF_STATUS, v);
        chk("status cleared", v, 0);
        idle(1);
        chk("int cleared", {31'b0, intr}, 0);
      end
    end
    $display("test event codes done");
    pulse(20'h00200);
    idle(4);
    rd_reg(OFF_SOURCE, v);
    chk("main refuses sub event", {31'b0, v[SRC_VALID_BIT]}, 0);
    wr_reg(OFF_CTRL, 32'h0);
    host_en = 1'b0;
    pulse(20'h00c06);
    idle(4);
    rd_reg(OFF_SOURCE, v);
    chk("sub refuses main events", {31'b0, v[SRC_VALID_BIT]}, 0);
    pulse(20'h00200);
    idle(4);
    rd_reg(OFF_SOURCE, v);
    chk("sub source", v, 32'h89);
    rd_reg(OFF_TYPE, v);
    chk("sub type", v, 32'h06);
    rd_reg(OFF_STATUS, v);
    $display("test roles done");
    wr_reg(OFF_CTRL, 32'h1);
    host_en = 1'b1;
    pulse(20'h80001);
    wait_act(1'b1);
    rd_reg(OFF_TYPE, v);
    chk("first taken", v, 32'h0a);
    wait_act(1'b1);
    rd_reg(OFF_TYPE, v);
    chk("second taken", v, 32'h17);
    rd_reg(OFF_STATUS, v);
    $display("test queue done");
    wr_reg(OFF_MASK, 32'h0);
    pulse(20'h00008);
    idle(4);
    chk("masked pin", {31'b0, act}, 0);
    chk("masked int", {31'b0, intr}, 0);
    rd_reg(OFF_STATUS, v);
    chk("masked status", v, 32'h8);
    wr_reg(OFF_MASK, 32'hffff_ffff);
    wait_act(1'b1);
    rd_reg(OFF_TYPE, v);
    chk("unmasked type", v, 32'h00);
    $display("test mask done");
    wr_reg(OFF_PIN_CONFIGURATION_REGISTER, 32'h1);
    inv = 1'b1;
    idle(2);
    chk("inverted idle", {31'b0, irq}, 1);
    pulse(20'h00010);
    wait_act(1'b1);
    chk("inverted active", {31'b0, irq}, 0);
    $display("test polarity done");
    @(posedge mclk_i);
    rst_st <= 1'b1;
    @(posedge mclk_i);
    rst_st <= 1'b0;
    idle(1);
    chk("oe in reset state", {31'b0, oe}, 0);
    chk("pin pulled low", {31'b0, pin}, 0);
    rd_reg(OFF_TYPE, v);
    chk("type after reset", v, 0);
    rd_reg(OFF_STATUS, v);
    chk("status after reset", v, 0);
    rd_reg(OFF_PIN_CONFIGURATION_REGISTER, v);
    chk("pin_configuration_register after reset", v, 0);
    $display("test reset state done");
    summarize();
  end
endmodule
